/* File: hdl/rsp_pkg.sv */
// package: register map, reset source codes and field layout for reset scope
// Functional notes
// - power-on detect flag is cleared only by a pin reset
// - power-on reset clears the cold/warm flag to 0, marking a cold start
// - software writes 1 to the cold/warm flag; kept through non power-on resets
// - independent watchdog flag/regs cleared by pin, power-on, vmon0, standby
// - deep standby resets only vmon1 control one and status
// - vmon2 flag cleared by pin, power-on, vmon0, both watchdogs and vmon1
// - deep standby resets only vmon2 control one and status
// - deep standby flag cleared by pin, power-on, vmons and watchdogs
// - software reset flag cleared by every source but software reset
// - clock registers writable only while first or second protect bit set
// - after any reset low-speed oscillator drives clocks; others stay stopped
// - one reset vector; cause readable from three reset status registers
package rsp_pkg;
	// reset source indices, one bit each in the source vector
	localparam int SRC_PIN = 0;
	localparam int SRC_POR = 1;
	localparam int SRC_VM0 = 2;
	localparam int SRC_IWD = 3;
	localparam int SRC_WDT = 4;
	localparam int SRC_VM1 = 5;
	localparam int SRC_VM2 = 6;
	localparam int SRC_DSB = 7;
	localparam int SRC_SWR = 8;
	localparam int NUM_SRC = 9;

	// register offsets (word index on the plain port)
	localparam logic [3:0] OFS_STATUS0 = 4'h0;
	localparam logic [3:0] OFS_STATUS1 = 4'h1;
	localparam logic [3:0] OFS_STATUS2 = 4'h2;
	localparam logic [3:0] OFS_PROTECT = 4'h3;
	localparam logic [3:0] OFS_SWRESET = 4'h4;
	localparam logic [3:0] OFS_CLKCTL = 4'h5;
	localparam logic [3:0] OFS_VM1CR1 = 4'h6;
	localparam logic [3:0] OFS_VM1SR = 4'h7;
	localparam logic [3:0] OFS_VM1CR0 = 4'h8;
	localparam logic [3:0] OFS_VM2CR1 = 4'h9;
	localparam logic [3:0] OFS_VM2SR = 4'hA;
	localparam logic [3:0] OFS_VM2CR0 = 4'hB;
	localparam logic [3:0] OFS_IWDCTL = 4'hC;
	localparam logic [3:0] OFS_IRQSTAT = 4'hD;
	localparam logic [3:0] OFS_IRQMASK = 4'hE;

	// status0 fields
	localparam int ST0_POR = 0;
	localparam int ST0_VM0 = 1;
	localparam int ST0_VM1 = 2;
	localparam int ST0_VM2 = 3;
	localparam int ST0_DSB = 4;
	// status2 fields
	localparam int ST2_IWD = 0;
	localparam int ST2_WDT = 1;
	localparam int ST2_SWR = 2;
	// status1 field
	localparam int ST1_CWF = 0;
	// protect register fields and write key in the upper byte
	localparam int PR_FIRST = 0;
	localparam int PR_SECOND = 1;
	localparam logic [7:0] PR_KEY = 8'hA5;
	localparam logic [15:0] SWR_KEY = 16'hA501;

	// clock control low-speed select, then reset values for clock, vmon and watchdog registers
	localparam logic [1:0] CLK_SEL_LOW = 2'h0;
	localparam logic [7:0] CLKCTL_RST = 8'h00;
	localparam logic [7:0] VM_RST = 8'h00;
	localparam logic [7:0] IWD_RST = 8'h00;

	// status snapshot carried as one group
	typedef struct packed
	{
		logic [4:0] st0;
		logic cwf;
		logic [2:0] st2;
	} rsp_flags_s;
endpackage

/* File: hdl/rsp_scope.sv */
// file holds the reset scope decoder: which targets a given source resets
`timescale 1ns/1ps
module rsp_scope
(
	input wire logic [rsp_pkg::NUM_SRC-1:0] src,
	output logic clr_por,
	output logic clr_cwf,
	output logic clr_vm0,
	output logic clr_iwd,
	output logic clr_wdt,
	output logic clr_vm1,
	output logic clr_vm1_part,
	output logic clr_vm2,
	output logic clr_vm2_part,
	output logic clr_dsb,
	output logic clr_swr,
	output logic clr_clk
);
	import rsp_pkg::*;

	// each target cleared by the union of sources in its column
	always_comb
	begin
		clr_por = src[SRC_PIN];
		clr_cwf = src[SRC_POR];
		clr_vm0 = src[SRC_PIN] | src[SRC_POR];
		clr_iwd = src[SRC_PIN] | src[SRC_POR] | src[SRC_VM0]
			| src[SRC_DSB];
		clr_wdt = clr_iwd | src[SRC_IWD];
		clr_vm1 = clr_vm0 | src[SRC_VM0] | src[SRC_IWD] | src[SRC_WDT];
		clr_vm1_part = clr_vm1 | src[SRC_DSB];
		clr_vm2 = clr_vm1 | src[SRC_VM1];
		clr_vm2_part = clr_vm2 | src[SRC_DSB];
		clr_dsb = clr_vm2 | src[SRC_VM2];
		clr_swr = |(src & ~(NUM_SRC'(1) << SRC_SWR));
		clr_clk = |src;
	end
endmodule

/* File: hdl/rsp_top.sv */
// file holds the reset source collector, flags, protect and clock select
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
module rsp_top
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [rsp_pkg::NUM_SRC-1:0] src_req,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	output logic sys_reset,
	output logic sw_reset_req,
	output logic [1:0] clk_sel,
	output logic [2:0] osc_en,
	output logic irq
);
	import rsp_pkg::*;

	//////////////////////////////////////////////////////////////////////
	// reset event capture: lowest source index wins when several fire
	logic [NUM_SRC-1:0] src_ff, nxt_src;
	logic sys_reset_ff, nxt_sys_reset;

	// a reset is sequenced: apply scope this cycle, cpu held one cycle
	always_comb
	begin
		nxt_src = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (src_req[i])
			begin
				nxt_src = '0;
				nxt_src[i] = 1'b1;
			end
		end
		nxt_sys_reset = |src_req;
	end

	// first release after resetn is treated as a power-on event
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			src_ff <= NUM_SRC'(1) << SRC_POR;
			sys_reset_ff <= 1'b1;
		end
		else
		begin
			src_ff <= nxt_src;
			sys_reset_ff <= nxt_sys_reset;
		end
	end

	logic clr_por, clr_cwf, clr_vm0, clr_iwd, clr_wdt, clr_vm1;
	logic clr_vm1_part, clr_vm2, clr_vm2_part, clr_dsb, clr_swr, clr_clk;

	rsp_scope u_scope
	(
		.src(src_ff),
		.clr_por(clr_por),
		.clr_cwf(clr_cwf),
		.clr_vm0(clr_vm0),
		.clr_iwd(clr_iwd),
		.clr_wdt(clr_wdt),
		.clr_vm1(clr_vm1),
		.clr_vm1_part(clr_vm1_part),
		.clr_vm2(clr_vm2),
		.clr_vm2_part(clr_vm2_part),
		.clr_dsb(clr_dsb),
		.clr_swr(clr_swr),
		.clr_clk(clr_clk)
	);

	//////////////////////////////////////////////////////////////////////
	// register state
	rsp_flags_s flg_ff, nxt_flg;
	logic [1:0] prot_ff, nxt_prot;
	logic [7:0] clkctl_ff, nxt_clkctl;
	logic [7:0] vm1cr1_ff, vm1sr_ff, vm1cr0_ff;
	logic [7:0] vm2cr1_ff, vm2sr_ff, vm2cr0_ff;
	logic [7:0] nxt_vm1cr1, nxt_vm1sr, nxt_vm1cr0;
	logic [7:0] nxt_vm2cr1, nxt_vm2sr, nxt_vm2cr0;
	logic [7:0] iwd_ff, nxt_iwd;
	logic [2:0] irqst_ff, nxt_irqst, irqmask_ff, nxt_irqmask;
	logic swr_ff, nxt_swr;
	logic any_src;
	logic wr_prot_ok_clk;

	assign any_src = |src_ff;
	// clock block writable under either protect bit
	assign wr_prot_ok_clk = prot_ff[PR_FIRST] | prot_ff[PR_SECOND];

	// next state for flags, protect, peripheral scope registers
	always_comb
	begin
		nxt_flg = flg_ff;
		nxt_prot = prot_ff;
		nxt_clkctl = clkctl_ff;
		nxt_vm1cr1 = vm1cr1_ff;
		nxt_vm1sr = vm1sr_ff;
		nxt_vm1cr0 = vm1cr0_ff;
		nxt_vm2cr1 = vm2cr1_ff;
		nxt_vm2sr = vm2sr_ff;
		nxt_vm2cr0 = vm2cr0_ff;
		nxt_iwd = iwd_ff;
		nxt_irqmask = irqmask_ff;
		nxt_swr = 1'b0;
		nxt_irqst = irqst_ff;
		// software writes, ignored while a reset is being applied
		if (wr && !any_src)
		begin
			case (addr)
				OFS_STATUS1:
				begin
					if (wdata[ST1_CWF])
						nxt_flg.cwf = 1'b1;
				end
				OFS_PROTECT:
				begin
					if (wdata[15:8] == PR_KEY)
						nxt_prot = wdata[1:0];
				end
				OFS_SWRESET:
				begin
					// silently dropped without second protect bit
					if (prot_ff[PR_SECOND] && wdata == SWR_KEY)
						nxt_swr = 1'b1;
				end
				OFS_CLKCTL:
				begin
					if (wr_prot_ok_clk)
						nxt_clkctl = wdata[7:0];
				end
				OFS_VM1CR1: nxt_vm1cr1 = wdata[7:0];
				OFS_VM1SR: nxt_vm1sr = wdata[7:0];
				OFS_VM1CR0: nxt_vm1cr0 = wdata[7:0];
				OFS_VM2CR1: nxt_vm2cr1 = wdata[7:0];
				OFS_VM2SR: nxt_vm2sr = wdata[7:0];
				OFS_VM2CR0: nxt_vm2cr0 = wdata[7:0];
				OFS_IWDCTL: nxt_iwd = wdata[7:0];
				OFS_IRQMASK: nxt_irqmask = wdata[2:0];
				default: ;
			endcase
		end
		// reading the interrupt status clears it
		if (rd && addr == OFS_IRQSTAT)
			nxt_irqst = 3'h0;
		// scope: clear targets of the captured source
		if (clr_por)
			nxt_flg.st0[ST0_POR] = 1'b0;
		if (clr_cwf)
			nxt_flg.cwf = 1'b0;
		if (clr_vm0)
			nxt_flg.st0[ST0_VM0] = 1'b0;
		if (clr_iwd)
		begin
			nxt_flg.st2[ST2_IWD] = 1'b0;
			nxt_iwd = IWD_RST;
		end
		if (clr_wdt)
			nxt_flg.st2[ST2_WDT] = 1'b0;
		if (clr_vm1)
		begin
			nxt_flg.st0[ST0_VM1] = 1'b0;
			nxt_vm1cr0 = VM_RST;
		end
		if (clr_vm1_part)
		begin
			nxt_vm1cr1 = VM_RST;
			nxt_vm1sr = VM_RST;
		end
		if (clr_vm2)
		begin
			nxt_flg.st0[ST0_VM2] = 1'b0;
			nxt_vm2cr0 = VM_RST;
		end
		if (clr_vm2_part)
		begin
			nxt_vm2cr1 = VM_RST;
			nxt_vm2sr = VM_RST;
		end
		if (clr_dsb)
			nxt_flg.st0[ST0_DSB] = 1'b0;
		if (clr_swr)
			nxt_flg.st2[ST2_SWR] = 1'b0;
		if (clr_clk)
		begin
			nxt_clkctl = CLKCTL_RST;
			nxt_prot = 2'h0;
			nxt_irqmask = 3'h0;
		end
		// own flag set last so it survives its own scope; set beats clear
		if (src_ff[SRC_POR])
			nxt_flg.st0[ST0_POR] = 1'b1;
		if (src_ff[SRC_VM0])
			nxt_flg.st0[ST0_VM0] = 1'b1;
		if (src_ff[SRC_VM1])
			nxt_flg.st0[ST0_VM1] = 1'b1;
		if (src_ff[SRC_VM2])
			nxt_flg.st0[ST0_VM2] = 1'b1;
		if (src_ff[SRC_DSB])
			nxt_flg.st0[ST0_DSB] = 1'b1;
		if (src_ff[SRC_IWD])
			nxt_flg.st2[ST2_IWD] = 1'b1;
		if (src_ff[SRC_WDT])
			nxt_flg.st2[ST2_WDT] = 1'b1;
		if (src_ff[SRC_SWR])
			nxt_flg.st2[ST2_SWR] = 1'b1;
		// interrupt events: any reset, cold start, software reset
		if (any_src)
			nxt_irqst[0] = 1'b1;
		if (src_ff[SRC_POR])
			nxt_irqst[1] = 1'b1;
		if (src_ff[SRC_SWR])
			nxt_irqst[2] = 1'b1;
	end

	// registered state; resetn stands for the power-on supply rise
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			flg_ff <= '0;
			prot_ff <= 2'h0;
			clkctl_ff <= CLKCTL_RST;
			vm1cr1_ff <= VM_RST;
			vm1sr_ff <= VM_RST;
			vm1cr0_ff <= VM_RST;
			vm2cr1_ff <= VM_RST;
			vm2sr_ff <= VM_RST;
			vm2cr0_ff <= VM_RST;
			iwd_ff <= IWD_RST;
			irqst_ff <= 3'h0;
			irqmask_ff <= 3'h0;
			swr_ff <= 1'b0;
		end
		else
		begin
			flg_ff <= nxt_flg;
			prot_ff <= nxt_prot;
			clkctl_ff <= nxt_clkctl;
			vm1cr1_ff <= nxt_vm1cr1;
			vm1sr_ff <= nxt_vm1sr;
			vm1cr0_ff <= nxt_vm1cr0;
			vm2cr1_ff <= nxt_vm2cr1;
			vm2sr_ff <= nxt_vm2sr;
			vm2cr0_ff <= nxt_vm2cr0;
			iwd_ff <= nxt_iwd;
			irqst_ff <= nxt_irqst;
			irqmask_ff <= nxt_irqmask;
			swr_ff <= nxt_swr;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// read port and registered outputs
	logic [15:0] rdata_ff, nxt_rdata;
	logic irq_ff, nxt_irq;
	logic [1:0] clk_sel_ff, nxt_clk_sel;
	logic [2:0] osc_en_ff, nxt_osc_en;

	// three status registers give the cause at the single vector
	always_comb
	begin
		nxt_rdata = 16'h0000;
		if (rd)
		begin
			case (addr)
				OFS_STATUS0: nxt_rdata = {11'h000, flg_ff.st0};
				OFS_STATUS1: nxt_rdata = {15'h0000, flg_ff.cwf};
				OFS_STATUS2: nxt_rdata = {13'h0000, flg_ff.st2};
				OFS_PROTECT: nxt_rdata = {14'h0000, prot_ff};
				OFS_CLKCTL: nxt_rdata = {8'h00, clkctl_ff};
				OFS_VM1CR1: nxt_rdata = {8'h00, vm1cr1_ff};
				OFS_VM1SR: nxt_rdata = {8'h00, vm1sr_ff};
				OFS_VM1CR0: nxt_rdata = {8'h00, vm1cr0_ff};
				OFS_VM2CR1: nxt_rdata = {8'h00, vm2cr1_ff};
				OFS_VM2SR: nxt_rdata = {8'h00, vm2sr_ff};
				OFS_VM2CR0: nxt_rdata = {8'h00, vm2cr0_ff};
				OFS_IWDCTL: nxt_rdata = {8'h00, iwd_ff};
				OFS_IRQSTAT: nxt_rdata = {13'h0000, irqst_ff};
				OFS_IRQMASK: nxt_rdata = {13'h0000, irqmask_ff};
				default: nxt_rdata = 16'h0000;
			endcase
		end
		nxt_irq = |(nxt_irqst & nxt_irqmask);
		// select stays low-speed until software picks another; an
		// oscillator only runs when its enable bit is written
		nxt_clk_sel = nxt_clkctl[1:0];
		nxt_osc_en = nxt_clkctl[4:2];
	end

	// output flops
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata_ff <= 16'h0000;
			irq_ff <= 1'b0;
			clk_sel_ff <= CLK_SEL_LOW;
			osc_en_ff <= 3'h0;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_irq;
			clk_sel_ff <= nxt_clk_sel;
			osc_en_ff <= nxt_osc_en;
		end
	end

	assign rdata = rdata_ff;
	assign irq = irq_ff;
	assign clk_sel = clk_sel_ff;
	assign osc_en = osc_en_ff;
	assign sys_reset = sys_reset_ff;
	assign sw_reset_req = swr_ff;
endmodule

/* File: tb/rsp_src_model.sv */
// reset source model: one-cycle requests, software reset echoed back
`timescale 1ns/1ps
module rsp_src_model
(
	input wire logic ref_clk,
	input wire logic fire,
	input wire logic [3:0] which,
	input wire logic sw_reset_req,
	output logic [rsp_pkg::NUM_SRC-1:0] src_req
);
	import rsp_pkg::*;
	logic [NUM_SRC-1:0] req;
	// a real source holds its line for one cycle only, never longer;
	// built in a local so the line is driven once per edge
	always @(posedge ref_clk)
	begin
		req = '0;
		if (fire)
			req[which] = 1'b1;
		if (sw_reset_req)
			req[SRC_SWR] = 1'b1;
		src_req <= req;
	end
endmodule

/* File: tb/rsp_chk_properties.sv */
// checker for port timing and causes of the reset scope block
`timescale 1ns/1ps
module rsp_chk
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [rsp_pkg::NUM_SRC-1:0] src_req,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic sys_reset,
	input wire logic sw_reset_req,
	input wire logic [1:0] clk_sel,
	input wire logic [2:0] osc_en,
	input wire logic irq
);
	import rsp_pkg::*;
	////////////////////////////////////////////////////////////////////
	// single domain, so clock and reset are given once
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	// keyed software reset write, then its request
	sequence s_key_wr;
		wr && addr == OFS_SWRESET && wdata == SWR_KEY;
	endsequence
	sequence s_key_req;
		s_key_wr ##1 sw_reset_req;
	endsequence
	////////////////////////////////////////////////////////////////////
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
		else $error("read data outside its slot");
	a_src_resets: assert property (|src_req |=> sys_reset)
		else $error("source gave no system reset");
	a_swreq_cause: assert property (sw_reset_req |-> $past(wr) &&
		$past(addr) == OFS_SWRESET && $past(wdata) == SWR_KEY)
		else $error("software reset without keyed write");
	a_swreq_pulse: assert property (s_key_req |=> !sw_reset_req)
		else $error("software reset request too long");
	a_clk_low: assert property (sys_reset |=>
		clk_sel == CLK_SEL_LOW && osc_en == 3'h0)
		else $error("clock not back on low-speed source");
	a_clk_cause: assert property ($changed({clk_sel, osc_en}) |->
		$past(wr) && $past(addr) == OFS_CLKCTL || sys_reset ||
		$past(sys_reset))
		else $error("clock control changed without a write");
	a_irq_rst: assert property (sys_reset |-> ##1 !irq)
		else $error("interrupt high after reset");
	a_irq_set: assert property ($rose(irq) |->
		$past(wr) && $past(addr) == OFS_IRQMASK ||
		$past(wr, 2) && $past(addr, 2) == OFS_IRQMASK)
		else $error("interrupt rose without a mask write");
endmodule

/* File: tb/tb.sv */
// self-checking bench for the reset scope block
`timescale 1ns/1ps
module tb;
	import rsp_pkg::*;
	// which sources clear each detection flag, by flag index
	localparam logic [8:0] CLR_BY [9] = '{9'h000, 9'h001, 9'h003, 9'h087,
		9'h08F, 9'h01F, 9'h03F, 9'h07F, 9'h0FF};
	localparam logic [3:0] RG [7] = '{OFS_VM1CR1, OFS_VM1CR0, OFS_VM2CR1,
		OFS_VM2CR0, OFS_IWDCTL, OFS_VM1SR, OFS_VM2SR};
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic fire = 1'b0;
	logic [3:0] which = 4'h0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata, g;
	logic [NUM_SRC-1:0] src_req;
	logic sys_reset, sw_reset_req, irq, cwf, seen;
	logic [1:0] clk_sel;
	logic [2:0] osc_en;
	logic [8:0] fl;
	logic [6:0] keep;
	int err_count = 0;
	int num_checks = 0;
	always #50 ref_clk = ~ref_clk;
	rsp_top rsp_top_i (.ref_clk(ref_clk), .resetn(resetn),
		.src_req(src_req), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .sys_reset(sys_reset), .sw_reset_req(sw_reset_req),
		.clk_sel(clk_sel), .osc_en(osc_en), .irq(irq));
	rsp_src_model rsp_src_model_i (.ref_clk(ref_clk), .fire(fire),
		.which(which), .sw_reset_req(sw_reset_req), .src_req(src_req));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe
	task automatic rreg(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// apply scope, then mark the causing source
	function automatic logic [8:0] upd(input logic [8:0] f,
		input logic [3:0] s);
		logic [8:0] n;
		n = f;
		for (int j = 0; j < 9; j++)
			if (CLR_BY[j][s])
				n[j] = 1'b0;
		n[s] = 1'b1;
		return n;
	endfunction
	task automatic chk_flags();
		rreg(OFS_STATUS0, g);
		chk(g, {11'h0, fl[7], fl[6], fl[5], fl[2], fl[1]});
		rreg(OFS_STATUS2, g);
		chk(g, {13'h0, fl[8], fl[4], fl[3]});
		rreg(OFS_STATUS1, g);
		chk(g, {15'h0, cwf});
	endtask
	task automatic pulse(input logic [3:0] s);
		@(posedge ref_clk);
		fire <= 1'b1;
		which <= s;
		@(posedge ref_clk);
		fire <= 1'b0;
		// model raises the line one edge later, cpu hold one after that
		@(posedge ref_clk);
		#1;
		chk(16'(sys_reset), 16'h0001);
		repeat (4) @(posedge ref_clk);
		chk(16'(sys_reset), 16'h0000);
		fl = upd(fl, s);
		if (s == 4'(SRC_POR))
			cwf = 1'b0;
		chk_flags();
	endtask
	// resetn stands for the supply rise: cold start, only por flag set
	task automatic rst_seq();
		resetn <= 1'b0;
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		fl = 9'h002;
		cwf = 1'b0;
		repeat (2) @(posedge ref_clk);
		chk_flags();
		chk(16'({clk_sel, osc_en}), 16'h0000);
	endtask
	// bounded wait: a missing request counts as a mismatch
	task automatic swr(input logic [15:0] pr, input logic exp);
		wreg(OFS_PROTECT, pr);
		wreg(OFS_SWRESET, SWR_KEY);
		seen = 1'b0;
		repeat (8) @(posedge ref_clk) seen |= sw_reset_req;
		chk(16'(seen), 16'(exp));
		if (exp)
		begin
			fl = upd(fl, 4'(SRC_SWR));
			chk_flags();
		end
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'hBFD6));
		rst_seq();
		chk(16'(irq), 16'h0000);
		wreg(OFS_IRQMASK, 16'h0003);
		repeat (2) @(posedge ref_clk);
		chk(16'(irq), 16'h0001);
		rreg(OFS_IRQSTAT, g);
		chk(g & 16'h0003, 16'h0003);
		repeat (2) @(posedge ref_clk);
		chk(16'(irq), 16'h0000);
		wreg(OFS_IRQMASK, 16'h0000);
		wreg(OFS_CLKCTL, 16'h001D);
		#1;
		chk(16'({clk_sel, osc_en}), 16'h0000);
		wreg(OFS_PROTECT, 16'hA501);
		// a write without the key leaves the protect bits alone
		wreg(OFS_PROTECT, 16'h5A02);
		rreg(OFS_PROTECT, g);
		chk(g, 16'h0001);
		wreg(OFS_CLKCTL, 16'h001D);
		#1;
		chk(16'({clk_sel, osc_en}), 16'h000F);
		pulse(4'(SRC_VM1));
		chk(16'({clk_sel, osc_en}), 16'h0000);
		swr(16'hA501, 1'b0);
		swr(16'hA502, 1'b1);
		// watchdog keeps the independent watchdog, standby keeps both vmon control zero registers
		for (int k = 0; k < 2; k++)
		begin
			foreach (RG[i])
				wreg(RG[i], 16'h0001);
			pulse(k ? 4'(SRC_DSB) : 4'(SRC_WDT));
			keep = k ? 7'b0001010 : 7'b0010000;
			foreach (RG[i])
			begin
				rreg(RG[i], g);
				chk(g, keep[i] ? 16'h0001 :
					16'(i == 4 ? IWD_RST : VM_RST));
			end
		end
		for (int n = 0; n < 30; n++)
		begin
			if ($urandom_range(1))
			begin
				wreg(OFS_STATUS1, 16'h0001);
				cwf = 1'b1;
			end
			pulse(4'($urandom_range(8)));
		end
		// a second supply rise mid-run must still mark a cold start
		wreg(OFS_STATUS1, 16'h0001);
		rst_seq();
		rreg(4'hF, g);
		chk(g, 16'h0000);
		tally_and_finish();
	end
endmodule
bind rsp_top rsp_chk rsp_chk_i (.ref_clk(ref_clk), .resetn(resetn),
	.src_req(src_req), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .sys_reset(sys_reset), .sw_reset_req(sw_reset_req),
	.clk_sel(clk_sel), .osc_en(osc_en), .irq(irq));
